/* File: inc/vip_pkg.sv */
// Constants, register map and carrier types for the vectored interrupt
// priority block. Assumes an AHB-Lite slave port with 32-bit data.
//
// Behaviour
// [RULE1] Control bit 0 enables normal vectoring, bit 1 enables fast vectoring (here bit 1 is only stored and read back).
// [RULE2] Up to eight nesting levels per class; fast always outranks normal. (here only the normal class nests; fast has no levels)
// [RULE3] Each prioritizable source has a 3-bit priority, values 0 to 7.
// [RULE4] Table base points at a table of 32 service-routine pointers.
// [RULE5] Base bits 15:0 read/write, reset zero; bits 31:16 read zero.
// [RULE6] Vector register shows base at bits 22:7; bits 31:23, 1:0 zero.
// [RULE7] Vector bits 6:2 carry index 0..21 of highest-priority active source.
// [RULE8] Second timer as winner reads index 00100.
// [RULE9] Software reads vector only after a normal interrupt with nesting on.
// [RULE10] Priority reg 0 fields 30:28, 26:24, 22:20: clock lock, converter, flash.
// [RULE11] Priority reg 0 fields 18:16, 14:12, 10:8, 6:4: timers two..zero, software.
// [RULE12] Priority reg 0 bits 3:0 reserved; source 0 is not prioritizable.
// [RULE13] Vector read with nesting on sets status bit of winner's priority.
// [RULE14] Status write clears only the highest-priority set bit per write.
// [RULE15] Nesting off: both classes still delivered, no priority, fast first.
// [RULE16] Ties in priority go to the lowest source index.
// [RULE17] Source field tracks sources live, reads zero with nothing pending.

package vip_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [31:0] ADDR_TABLE_BASE   = 32'hffff_0014;
  localparam logic [31:0] ADDR_VECTOR_PTR   = 32'hffff_001c;
  localparam logic [31:0] ADDR_SRC_PRIO_0   = 32'hffff_0020;
  localparam logic [31:0] ADDR_VECTOR_CTRL  = 32'hffff_0030;
  localparam logic [31:0] ADDR_ACTIVE_STAT  = 32'hffff_003c;
  localparam logic [31:0] ADDR_EVENT_STAT   = 32'hffff_0040;
  localparam logic [31:0] ADDR_EVENT_MASK   = 32'hffff_0044;

  // ----------------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------------
  localparam int          NUM_SOURCES       = 22;
  localparam int          TABLE_ENTRIES     = 32;
  localparam int          NUM_LEVELS        = 8;
  localparam int          BASE_WIDTH        = 16;
  localparam int          VEC_BASE_LSB      = 7;
  localparam int          VEC_INDEX_LSB     = 2;
  localparam int          CTRL_NORMAL_BIT   = 0;
  localparam int          CTRL_FAST_BIT     = 1;
  localparam logic [31:0] PRIO0_WRITE_MASK  = 32'h7777_7770;
  localparam logic [31:0] RESET_WORD        = 32'h0000_0000;
  localparam logic [2:0]  FIXED_PRIO        = 3'h7;
  localparam logic [2:0]  SOURCE0_PRIO      = 3'h0;
  // Sources 1..7 take their level from priority reg 0, nibble 1..7
  localparam int          PRIO0_FIRST_SRC   = 1;
  localparam int          PRIO0_LAST_SRC    = 7;

  // Event status bits
  localparam int          EV_NEST_ENTER     = 0;
  localparam int          EV_NEST_EXIT      = 1;
  localparam int          EV_EMPTY_READ     = 2;
  localparam int          NUM_EVENTS        = 3;

  // AHB encodings
  localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
  localparam logic        HRESP_OKAY        = 1'b0;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic        write;
  } vip_req_s;

  typedef struct packed {
    logic       valid;
    logic [4:0] index;
    logic [2:0] level;
  } vip_pick_s;

endpackage

/* File: rtl/vip_top.sv */
// Vectored interrupt priority block: nesting state, per-source priority,
// vector formation and an AHB-Lite register slave.
// Assumes source request levels come from logic on the same clock.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/10ps

module vip_top #(
  parameter int NSRC = vip_pkg::NUM_SOURCES
) (
  input  wire logic              CORE_CLK_IN,
  input  wire logic              RST_IN,
  input  wire logic              HSEL_IN,
  input  wire logic [31:0]       HADDR_IN,
  input  wire logic [1:0]        HTRANS_IN,
  input  wire logic              HWRITE_IN,
  input  wire logic [2:0]        HSIZE_IN,
  input  wire logic [31:0]       HWDATA_IN,
  input  wire logic              HREADY_IN,
  input  wire logic [NSRC-1:0]   NORMAL_ACTIVE_IN,
  input  wire logic [NSRC-1:0]   FAST_ACTIVE_IN,
  output logic [31:0]            HRDATA_OUT,
  output logic                   HREADYOUT_OUT,
  output logic                   HRESP_OUT,
  output logic                   NORMAL_REQ_OUT,
  output logic                   FAST_REQ_OUT,
  output logic                   INT_OUT
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------

  // Level of one source; source 0 and sources beyond reg 0 are fixed
  function automatic logic [2:0] level_of(input logic [31:0] prio0, input int idx);
    logic [2:0] lv;
    lv = vip_pkg::FIXED_PRIO;
    if (idx == 0) begin
      lv = vip_pkg::SOURCE0_PRIO;                                   // [RULE12]
    end else if (idx >= vip_pkg::PRIO0_FIRST_SRC && idx <= vip_pkg::PRIO0_LAST_SRC) begin
      lv = prio0[idx*4 +: 3];                                       // [RULE10] [RULE11]
    end
    return lv;
  endfunction

  // True when an entered level at or above this one is still in service
  function automatic logic level_blocked(input logic [7:0] stat, input logic [2:0] lv);
    logic bl;
    bl = 1'b0;
    for (int j = 0; j < vip_pkg::NUM_LEVELS; j++) begin
      if (stat[j] && (3'(j) <= lv)) begin
        bl = 1'b1;
      end
    end
    return bl;
  endfunction

  // Lowest set bit cleared; bit 0 is the highest priority level
  function automatic logic [7:0] clear_top(input logic [7:0] stat);
    logic [7:0] res;
    logic       done;
    res  = stat;
    done = 1'b0;
    for (int j = 0; j < vip_pkg::NUM_LEVELS; j++) begin
      if (stat[j] && !done) begin
        res[j] = 1'b0;
        done   = 1'b1;
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [vip_pkg::BASE_WIDTH-1:0] base_q;
  logic [31:0]                    prio0_q;
  logic                           normal_nest_enable_q;
  logic                           fast_nest_enable_q;
  logic [7:0]                     active_stat_q;
  logic [7:0]                     active_stat_d;
  logic [vip_pkg::NUM_EVENTS-1:0] ev_stat_q;
  logic [vip_pkg::NUM_EVENTS-1:0] ev_stat_d;
  logic [vip_pkg::NUM_EVENTS-1:0] ev_mask_q;
  logic [vip_pkg::NUM_EVENTS-1:0] ev_set;
  vip_pkg::vip_req_s              req_q;
  logic                           pend_q;
  logic [31:0]                    rdata_q;
  logic                           hready_q;
  logic                           normal_req_q;
  logic                           fast_req_q;
  logic                           int_q;

  // ----------------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------------

  // Scan from the top so the lowest index wins a tie on level
  vip_pkg::vip_pick_s pick;
  always_comb begin
    logic [2:0] lv;
    lv   = 3'h0;
    pick = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      lv = normal_nest_enable_q ? level_of(prio0_q, i) : 3'h0;     // [RULE15]
      if (NORMAL_ACTIVE_IN[i] && !(normal_nest_enable_q && level_blocked(active_stat_q, lv))
          && (!pick.valid || lv <= pick.level)) begin               // [RULE16] [RULE2]
        pick.valid = 1'b1;
        pick.index = 5'(i);                                         // [RULE7] [RULE8]
        pick.level = lv;
      end
    end
  end

  // Vector word: base scaled into the 32-entry pointer table
  wire [31:0] vector_word = {9'h000, base_q, pick.valid ? pick.index : 5'h00, 2'b00};  // [RULE6] [RULE17] [RULE4]

  // Request to the core: fast first, normal held back while fast pending
  wire fast_any   = |FAST_ACTIVE_IN;
  wire normal_any = pick.valid & ~fast_any;                         // [RULE2] [RULE15]

  // ----------------------------------------------------------------------
  // AHB-Lite decode
  // ----------------------------------------------------------------------
  wire addr_take  = HSEL_IN & HREADY_IN & (HTRANS_IN == vip_pkg::HTRANS_NONSEQ);
  wire do_wr      = pend_q & req_q.write;
  wire do_rd      = pend_q & ~req_q.write;
  wire hit_base   = req_q.addr == vip_pkg::ADDR_TABLE_BASE;
  wire hit_vec    = req_q.addr == vip_pkg::ADDR_VECTOR_PTR;
  wire hit_prio0  = req_q.addr == vip_pkg::ADDR_SRC_PRIO_0;
  wire hit_ctrl   = req_q.addr == vip_pkg::ADDR_VECTOR_CTRL;
  wire hit_astat  = req_q.addr == vip_pkg::ADDR_ACTIVE_STAT;
  wire hit_evstat = req_q.addr == vip_pkg::ADDR_EVENT_STAT;
  wire hit_evmask = req_q.addr == vip_pkg::ADDR_EVENT_MASK;

  // Read mux; unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = vip_pkg::RESET_WORD;
    if (hit_base)   rd_mux = {16'h0000, base_q};                     // [RULE5]
    if (hit_vec)    rd_mux = vector_word;
    if (hit_prio0)  rd_mux = prio0_q;
    if (hit_ctrl)   rd_mux = {30'h0000_0000, fast_nest_enable_q, normal_nest_enable_q};
    if (hit_astat)  rd_mux = {24'h00_0000, active_stat_q};
    if (hit_evstat) rd_mux = {29'h0000_0000, ev_stat_q};
    if (hit_evmask) rd_mux = {29'h0000_0000, ev_mask_q};
  end

  // ----------------------------------------------------------------------
  // Nesting status and events
  // ----------------------------------------------------------------------
  wire vec_read  = do_rd & hit_vec;
  wire nest_in   = vec_read & normal_nest_enable_q & pick.valid;    // [RULE13] [RULE9]
  wire nest_out  = do_wr & hit_astat & (|active_stat_q);

  always_comb begin
    active_stat_d = active_stat_q;
    if (nest_in) begin
      active_stat_d[pick.level] = 1'b1;                             // [RULE13]
    end else if (nest_out) begin
      active_stat_d = clear_top(active_stat_q);                     // [RULE14]
    end
  end

  // Event set beats a write-one clear in the same cycle
  assign ev_set = {vec_read & ~pick.valid, nest_out, nest_in};
  assign ev_stat_d = (ev_stat_q & ~((do_wr & hit_evstat) ? HWDATA_IN[vip_pkg::NUM_EVENTS-1:0] :
                     {vip_pkg::NUM_EVENTS{1'b0}})) | ev_set;

  // ----------------------------------------------------------------------
  // Bus slave: one wait state so read data comes from a flop
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      req_q    <= '0;
      pend_q   <= 1'b0;
      hready_q <= 1'b1;
      rdata_q  <= vip_pkg::RESET_WORD;
    end else begin
      pend_q   <= addr_take;
      hready_q <= ~addr_take;
      if (addr_take) begin
        req_q <= '{addr: HADDR_IN, write: HWRITE_IN};
      end
      if (do_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      base_q               <= '0;                                    // [RULE5]
      prio0_q              <= vip_pkg::RESET_WORD;
      normal_nest_enable_q <= 1'b0;
      fast_nest_enable_q   <= 1'b0;
      ev_mask_q            <= '0;
    end else if (do_wr) begin
      if (hit_base)   base_q  <= HWDATA_IN[vip_pkg::BASE_WIDTH-1:0]; // [RULE5]
      if (hit_prio0)  prio0_q <= HWDATA_IN & vip_pkg::PRIO0_WRITE_MASK; // [RULE3] [RULE12]
      if (hit_ctrl) begin
        normal_nest_enable_q <= HWDATA_IN[vip_pkg::CTRL_NORMAL_BIT];  // [RULE1]
        fast_nest_enable_q   <= HWDATA_IN[vip_pkg::CTRL_FAST_BIT];    // [RULE1]
      end
      if (hit_evmask) ev_mask_q <= HWDATA_IN[vip_pkg::NUM_EVENTS-1:0];
    end
  end

  // State updated by hardware
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      active_stat_q <= 8'h00;
      ev_stat_q     <= '0;
      normal_req_q  <= 1'b0;
      fast_req_q    <= 1'b0;
      int_q         <= 1'b0;
    end else begin
      active_stat_q <= active_stat_d;
      ev_stat_q     <= ev_stat_d;
      normal_req_q  <= normal_any;
      fast_req_q    <= fast_any;                                    // [RULE15]
      int_q         <= |(ev_stat_d & ev_mask_q);
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign HRDATA_OUT     = rdata_q;
  assign HREADYOUT_OUT  = hready_q;
  assign HRESP_OUT      = vip_pkg::HRESP_OKAY;
  assign NORMAL_REQ_OUT = normal_req_q;
  assign FAST_REQ_OUT   = fast_req_q;
  assign INT_OUT        = int_q;

  // Size is ignored: only whole-word transfers are supported
  wire unused_size = ^HSIZE_IN;

endmodule // vip_top

/* File: bench/vip_top_properties.sv */
// Checker for the vectored priority block, bound to its top module.
// Assumes HREADY_IN is tied to HREADYOUT_OUT and a single clock.
`timescale 1ns/10ps
module vip_chk #(parameter int NSRC = vip_pkg::NUM_SOURCES) (
  input wire logic            CORE_CLK_IN,
  input wire logic            RST_IN,
  input wire logic            HSEL_IN,
  input wire logic [31:0]     HADDR_IN,
  input wire logic [1:0]      HTRANS_IN,
  input wire logic            HWRITE_IN,
  input wire logic            HREADY_IN,
  input wire logic [NSRC-1:0] NORMAL_ACTIVE_IN,
  input wire logic [NSRC-1:0] FAST_ACTIVE_IN,
  input wire logic [31:0]     HRDATA_OUT,
  input wire logic            NORMAL_REQ_OUT,
  input wire logic            FAST_REQ_OUT,
  input wire logic            INT_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  // Taken read phases by target; read data lands two edges later
  wire logic rd      = HSEL_IN && HREADY_IN && HTRANS_IN == vip_pkg::HTRANS_NONSEQ && !HWRITE_IN;
  wire logic rd_base = rd && HADDR_IN == vip_pkg::ADDR_TABLE_BASE;
  wire logic rd_vec  = rd && HADDR_IN == vip_pkg::ADDR_VECTOR_PTR;
  wire logic rd_prio = rd && HADDR_IN == vip_pkg::ADDR_SRC_PRIO_0;
  a_base_upper_zero: assert property (rd_base |-> ##2 HRDATA_OUT[31:16] == 16'h0000)
    else $error("base upper half not zero");
  a_vec_zero_bits: assert property (rd_vec |-> ##2 HRDATA_OUT[31:23] == 9'h000 && HRDATA_OUT[1:0] == 2'h0)
    else $error("vector reserved bits not zero");
  a_vec_index_max: assert property (rd_vec |-> ##2 HRDATA_OUT[6:2] <= 5'h15)
    else $error("vector index above last source");
  a_vec_none_zero: assert property (rd_vec ##1 NORMAL_ACTIVE_IN == '0 |=> HRDATA_OUT[6:2] == 5'h00)
    else $error("vector index not zero when idle");
  a_prio_reserved: assert property (rd_prio |-> ##2 (HRDATA_OUT & ~vip_pkg::PRIO0_WRITE_MASK) == 32'h0000_0000)
    else $error("priority reserved bits set");
  a_fast_follows: assert property (!$past(RST_IN) |-> FAST_REQ_OUT == |$past(FAST_ACTIVE_IN))
    else $error("fast request does not follow sources");
  a_normal_yields: assert property (!$past(RST_IN) && |$past(FAST_ACTIVE_IN) |-> !NORMAL_REQ_OUT)
    else $error("normal request beside fast");
  a_normal_idle: assert property (!$past(RST_IN) && $past(NORMAL_ACTIVE_IN) == '0 |-> !NORMAL_REQ_OUT)
    else $error("normal request with no source");
  // Main scenarios reached
  c_timer_two: cover property (rd_vec ##2 HRDATA_OUT[6:2] == 5'h04);
  c_int_rise: cover property ($rose(INT_OUT));
  c_fast_wins: cover property (FAST_REQ_OUT && |NORMAL_ACTIVE_IN && !NORMAL_REQ_OUT);
endmodule // vip_chk
bind vip_top vip_chk #(.NSRC(NSRC)) vip_chk_i (.CORE_CLK_IN, .RST_IN, .HSEL_IN, .HADDR_IN, .HTRANS_IN,
  .HWRITE_IN, .HREADY_IN, .NORMAL_ACTIVE_IN, .FAST_ACTIVE_IN, .HRDATA_OUT, .NORMAL_REQ_OUT, .FAST_REQ_OUT, .INT_OUT);

/* File: bench/vip_core_model.sv */
// Stand-in for the core and the peripherals that raise sources.
// Assumes the block's clock; source levels move only at rising edges.
`timescale 1ns/10ps
module vip_core_model #(parameter int NSRC = vip_pkg::NUM_SOURCES) (
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire logic [NSRC-1:0] norm_cmd_in,
  input  wire logic [NSRC-1:0] fast_cmd_in,
  input  wire logic            normal_req_in,
  output logic [NSRC-1:0]      norm_src_out,
  output logic [NSRC-1:0]      fast_src_out,
  output logic                 irq_seen_out
);
  // Registered like peripheral flags, so sources never glitch mid-cycle
  always_ff @(posedge clk_in) begin
    norm_src_out <= rst_in ? '0 : norm_cmd_in;
    fast_src_out <= rst_in ? '0 : fast_cmd_in;
  end
  // Software fetches the vector only once a normal request is seen
  assign irq_seen_out = normal_req_in;
endmodule // vip_core_model

/* File: bench/vip_top_tb_top.sv */
// Self-checking bench for the vectored priority block.
// Assumes AHB-Lite register access and sources driven by the core model.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; \
  if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module vip_top_tb_top;
  localparam int   NSRC = vip_pkg::NUM_SOURCES;
  logic            clk    = 1'b0;
  logic            rst    = 1'b1;
  logic [31:0]     haddr  = 32'h0000_0000;
  logic [1:0]      htrans = 2'h0;
  logic            hwrite = 1'b0;
  logic [31:0]     hwdata = 32'h0000_0000;
  logic [NSRC-1:0] ncmd   = '0;
  logic [NSRC-1:0] fcmd   = '0;
  logic [NSRC-1:0] nsrc, fsrc;
  logic [31:0]     hrdata;
  logic            hready, nreq, freq, irq, seen, hresp;
  int              n_fail = 0;
  int              checks = 0;
  int              cyc    = 0;
  vip_top vip_top_i (.CORE_CLK_IN(clk), .RST_IN(rst), .HSEL_IN(1'b1), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready), .NORMAL_ACTIVE_IN(nsrc),
    .FAST_ACTIVE_IN(fsrc), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .NORMAL_REQ_OUT(nreq),
    .FAST_REQ_OUT(freq), .INT_OUT(irq));
  vip_core_model vip_core_model_i (.clk_in(clk), .rst_in(rst), .norm_cmd_in(ncmd), .fast_cmd_in(fcmd),
    .normal_req_in(nreq), .norm_src_out(nsrc), .fast_src_out(fsrc), .irq_seen_out(seen));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // A hung handshake would stall forever, so cap the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic test_done();
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One single transfer: hold address until ready, then data until ready
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    htrans <= vip_pkg::HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic chk_rd(input string n, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    `CHK(n, e, r)
  endtask
  // Reset values, writable fields and a hole in the map
  task automatic t_regs();
    chk_rd("base", vip_pkg::ADDR_TABLE_BASE, 32'h0000_0000);
    chk_rd("prio", vip_pkg::ADDR_SRC_PRIO_0, 32'h0000_0000);
    wr(vip_pkg::ADDR_TABLE_BASE, 32'hffff_ffff);
    chk_rd("base rw", vip_pkg::ADDR_TABLE_BASE, 32'h0000_ffff);
    wr(vip_pkg::ADDR_SRC_PRIO_0, 32'hffff_ffff);
    chk_rd("prio rw", vip_pkg::ADDR_SRC_PRIO_0, 32'h7777_7770);
    wr(vip_pkg::ADDR_VECTOR_CTRL, 32'h0000_0003);
    chk_rd("ctrl", vip_pkg::ADDR_VECTOR_CTRL, 32'h0000_0003);
    wr(32'hffff_0050, 32'hffff_ffff);
    chk_rd("hole", 32'hffff_0050, 32'h0000_0000);
    `CHK("resp", vip_pkg::HRESP_OKAY, hresp)
  endtask
  // Plain mode: a fast source silences the normal request
  task automatic t_plain();
    wr(vip_pkg::ADDR_VECTOR_CTRL, 32'h0000_0000);
    ncmd <= 22'h00_0004;
    repeat (3) @(posedge clk);
    `CHK("nreq", 1'b1, nreq)
    fcmd <= 22'h00_0020;
    repeat (3) @(posedge clk);
    `CHK("fast", 2'b10, {freq, nreq})
    ncmd <= '0;
    fcmd <= '0;
  endtask
  task automatic nest_step(input logic [NSRC-1:0] s, input logic [31:0] v, input logic [7:0] st);
    ncmd <= s;
    repeat (3) @(posedge clk);
    `CHK("seen", 1'b1, seen)
    chk_rd("vec", vip_pkg::ADDR_VECTOR_PTR, v);
    chk_rd("stat", vip_pkg::ADDR_ACTIVE_STAT, {24'h00_0000, st});
  endtask
  // Nesting: winner by level then index, blocking, one clear per write
  task automatic t_nest();
    wr(vip_pkg::ADDR_VECTOR_CTRL, 32'h0000_0001);
    wr(vip_pkg::ADDR_SRC_PRIO_0, 32'h7771_1750);
    nest_step(22'h00_0212, 32'h007f_ff90, 8'h02);
    wr(vip_pkg::ADDR_ACTIVE_STAT, 32'h0000_00ff);
    nest_step(22'h00_021a, 32'h007f_ff8c, 8'h02);
    nest_step(22'h00_021b, 32'h007f_ff80, 8'h03);
    wr(vip_pkg::ADDR_ACTIVE_STAT, 32'h0000_00ff);
    chk_rd("clr1", vip_pkg::ADDR_ACTIVE_STAT, 32'h0000_0002);
    wr(vip_pkg::ADDR_ACTIVE_STAT, 32'h0000_00ff);
    chk_rd("clr2", vip_pkg::ADDR_ACTIVE_STAT, 32'h0000_0000);
    ncmd <= '0;
  endtask
  // Events latch, the mask gates the line, ones written clear them
  task automatic t_irq();
    chk_rd("vec idle", vip_pkg::ADDR_VECTOR_PTR, 32'h007f_ff80);
    chk_rd("events", vip_pkg::ADDR_EVENT_STAT, 32'h0000_0007);
    `CHK("irq off", 1'b0, irq)
    wr(vip_pkg::ADDR_EVENT_MASK, 32'h0000_0004);
    repeat (2) @(posedge clk);
    `CHK("irq on", 1'b1, irq)
    wr(vip_pkg::ADDR_EVENT_STAT, 32'h0000_0004);
    repeat (2) @(posedge clk);
    `CHK("irq clr", 1'b0, irq)
    chk_rd("ev left", vip_pkg::ADDR_EVENT_STAT, 32'h0000_0003);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_plain();
    t_nest();
    t_irq();
    test_done();
  end
endmodule // vip_top_tb_top
